// ---- common/deframer_map.vh ----
/*
 * deframer_map.vh: register offsets, bit positions, reset values and the
 * symbol codes used by the deframer lane sync control block.
 * assumes: included by bare name from the design files.
 */
`ifndef DEFRAMER_MAP_VH
`define DEFRAMER_MAP_VH

// register indices; 0x475 is not word aligned, so the bus byte address is index * 4
`define REG_IDX_DEFRAMER_CONTROL_0 12'h475
`define REG_IDX_SYNC_STATUS 12'h476
`define REG_IDX_IRQ_STATUS 12'h477
`define REG_IDX_IRQ_MASK 12'h478
`define ADDR_W 14

// deframer_control_0 fields
`define CTRL_RX_DISABLE_BIT 7
`define CTRL_REPLACE_DISABLE_BIT 6
`define CTRL_SKIP_ILAS_BIT 4
`define CTRL_SOFT_RESET_BIT 3
`define CTRL_RESET 8'h00

// sync status fields
`define SYNC_LANE0_BIT 0
`define SYNC_LANE1_BIT 1
`define SYNC_RESET 8'h00

// irq status / mask fields
`define IRQ_LANE0_LOST_BIT 0
`define IRQ_LANE1_LOST_BIT 1
`define IRQ_LANE0_GAINED_BIT 2
`define IRQ_LANE1_GAINED_BIT 3
`define IRQ_RESET 4'h0

// control character codes (k flag carried separately)
`define CHAR_K28_0 8'h1c
`define CHAR_K28_3 8'h7c
`define CHAR_K28_7 8'hfc

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- dv/deframer_lane_sync_control_sva.sv ----
/* deframer_lane_sync_control_sva: port-level assertions.
   assumes: bound to the top module, one clock mclk_i. */
`timescale 1ns/1ps
`default_nettype none
module deframer_lane_sync_control_sva #(
  parameter LANES = 2
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [LANES-1:0] lane_valid_i,
  input wire logic [LANES-1:0] lane_valid_o,
  input wire logic receiver_enable_o,
  input wire logic deframer_core_reset_o,
  input wire logic irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o) else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer not held");
  // both taken at one edge: the write commits at the next edge, bvalid is seen one edge later
  wr_answer_a: assert property (s_axi_awready_o && s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("no bvalid");
  rd_answer_a: assert property (s_axi_arready_o |=> s_axi_rvalid_o) else $error("no rvalid");
  aw_pulse_a: assert property (s_axi_awready_o |=> !s_axi_awready_o) else $error("awready not a pulse");
  lane_off_a: assert property (
    (!receiver_enable_o || deframer_core_reset_o) [*3] |-> lane_valid_o == '0) else $error("lane out while off");
  lane_pass_a: assert property (
    (receiver_enable_o && !deframer_core_reset_o) [*4] |-> lane_valid_o == $past(lane_valid_i, 2))
    else $error("lane valid not delayed by two");
  reset_state_a: assert property (disable iff (1'b0)
    rst_i |=> !irq_o && !s_axi_bvalid_o && !s_axi_rvalid_o && deframer_core_reset_o && !receiver_enable_o)
    else $error("bad reset state");
  cover property (irq_o);
  cover property (lane_valid_o[0]);
  cover property (s_axi_bvalid_o && s_axi_bready_i);
endmodule // deframer_lane_sync_control_sva
bind deframer_lane_sync_control deframer_lane_sync_control_sva #(.LANES(LANES)) i_sva (.mclk_i(mclk_i),
  .rst_i(rst_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
  .lane_valid_i(lane_valid_i), .lane_valid_o(lane_valid_o), .receiver_enable_o(receiver_enable_o),
  .deframer_core_reset_o(deframer_core_reset_o), .irq_o(irq_o));
`default_nettype wire

// ---- dv/deframer_lane_sync_control_tb_top.sv ----
/* deframer_lane_sync_control_tb_top: axi4-lite master, queued expectations.
   assumes: lane_tx_model on the lanes, checker bound separately. */
`timescale 1ns/1ps
`default_nettype none
`include "deframer_map.vh"
module deframer_lane_sync_control_tb_top;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [13:0] aw = 14'h0000;
  logic [13:0] ar = 14'h0000;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  wire awr, wrd, bv, arr, rv, ren, crst, skip, irq;
  wire [1:0] br, rr, sync, lvi, lki, lfe, lvo, lko;
  wire [31:0] rd;
  wire [15:0] ldi, ldo;
  int err_total = 0;
  int compares = 0;
  logic [33:0] bq[$], rq[$], lq[$];
  always #20 mclk_i = ~mclk_i;
  deframer_lane_sync_control i_deframer_lane_sync_control (.mclk_i(mclk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(br),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rry), .lane_sync_i(sync), .lane_valid_i(lvi), .lane_data_i(ldi),
    .lane_is_k_i(lki), .lane_frame_end_i(lfe), .lane_valid_o(lvo), .lane_data_o(ldo),
    .lane_is_k_o(lko), .receiver_enable_o(ren), .deframer_core_reset_o(crst),
    .skip_initial_alignment_sequence_o(skip), .irq_o(irq));
  lane_tx_model i_lane_tx_model (.mclk_i(mclk_i), .sync_o(sync), .valid_o(lvi), .data_o(ldi),
    .is_k_o(lki), .frame_end_o(lfe));
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    if (bv && bry) chk({32'h0, br}, bq.pop_front());
    if (rv && rry) chk({rr, rd}, rq.pop_front());
    if (lvo != 2'b00) chk({14'h0, lvo, lko, ldo}, lq.size() ? lq.pop_front() : 34'h0);
  end
  task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] e);
    @(posedge mclk_i);
    bq.push_back({32'h0, e});
    aw <= {idx, 2'b00};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while ((awv && !awr) || (wv && !wrd));
    // a late bready lets the response wait on the master
    repeat ($urandom_range(2)) @(posedge mclk_i);
    bry <= 1'b1;
    do @(posedge mclk_i); while (!bv);
    bry <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] idx, input logic [33:0] e);
    @(posedge mclk_i);
    rq.push_back(e);
    ar <= {idx, 2'b00};
    arv <= 1'b1;
    do @(posedge mclk_i); while (!arr);
    arv <= 1'b0;
    repeat ($urandom_range(2)) @(posedge mclk_i);
    rry <= 1'b1;
    do @(posedge mclk_i); while (!rv);
    rry <= 1'b0;
  endtask
  // odd octets end a frame; every second frame ends in an alignment character
  task automatic frames(input logic pass, input logic run);
    logic [7:0] d, last;
    logic k;
    last = 8'h00;
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      k = (i % 4 == 3);
      if (k) d = (i == 3) ? `CHAR_K28_3 : `CHAR_K28_7;
      if (run) lq.push_back({14'h0, 2'b11, {2{k && pass}}, {2{(k && !pass) ? last : d}}});
      if (i % 4 == 1) last = d;
      i_lane_tx_model.send(d, k, i[0], $urandom_range(2));
    end
    repeat (6) @(posedge mclk_i);
    chk(34'(lq.size()), 34'h0);
  endtask
  initial begin
    void'($urandom(32'hf48c6027));
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    rdc(`REG_IDX_DEFRAMER_CONTROL_0, {`RESP_OKAY, 24'h0, `CTRL_RESET});
    rdc(`REG_IDX_SYNC_STATUS, {`RESP_OKAY, 24'h0, `SYNC_RESET});
    wr(`REG_IDX_IRQ_MASK, 8'h04, `RESP_OKAY);
    i_lane_tx_model.set_sync(2'b11);
    repeat (10) @(posedge mclk_i);
    rdc(`REG_IDX_SYNC_STATUS, {`RESP_OKAY, 32'h3});
    chk({33'h0, irq}, 34'h1);
    rdc(`REG_IDX_IRQ_STATUS, {`RESP_OKAY, 32'hc});
    repeat (3) @(posedge mclk_i);
    chk({33'h0, irq}, 34'h0);
    i_lane_tx_model.set_sync(2'b10);
    repeat (10) @(posedge mclk_i);
    rdc(`REG_IDX_SYNC_STATUS, {`RESP_OKAY, 32'h2});
    chk({33'h0, irq}, 34'h0);
    rdc(`REG_IDX_IRQ_STATUS, {`RESP_OKAY, 32'h1});
    $display("test sync and irq done");
    frames(1'b0, 1'b1);
    $display("test replace done");
    wr(`REG_IDX_DEFRAMER_CONTROL_0, 8'h18, `RESP_OKAY);
    wr(`REG_IDX_DEFRAMER_CONTROL_0, 8'hd8, `RESP_OKAY);
    rdc(`REG_IDX_DEFRAMER_CONTROL_0, {`RESP_OKAY, 32'hd8});
    chk({31'h0, ren, crst, skip}, 34'h3);
    frames(1'b1, 1'b0);
    wr(`REG_IDX_DEFRAMER_CONTROL_0, 8'hd0, `RESP_OKAY);
    // the pin outputs follow the register one edge after the write commits
    repeat (2) @(posedge mclk_i);
    chk({31'h0, ren, crst, skip}, 34'h1);
    frames(1'b1, 1'b0);
    wr(`REG_IDX_DEFRAMER_CONTROL_0, 8'hd8, `RESP_OKAY);
    wr(`REG_IDX_DEFRAMER_CONTROL_0, 8'h58, `RESP_OKAY);
    wr(`REG_IDX_DEFRAMER_CONTROL_0, 8'h50, `RESP_OKAY);
    repeat (3) @(posedge mclk_i);
    chk({31'h0, ren, crst, skip}, 34'h5);
    frames(1'b1, 1'b1);
    $display("test disable done");
    wr(12'h000, 8'h55, `RESP_SLVERR);
    rdc(12'h000, {`RESP_SLVERR, 32'h0});
    $display("test unmapped done");
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    print_verdict();
  end
endmodule // deframer_lane_sync_control_tb_top
`default_nettype wire

// ---- dv/lane_tx_model.sv ----
/* lane_tx_model: far-end transmitter driving both lanes with one octet stream.
   assumes: caller is at a rising edge of mclk_i. */
`timescale 1ns/1ps
`default_nettype none
module lane_tx_model (
  input wire logic mclk_i,
  output logic [1:0] sync_o,
  output logic [1:0] valid_o,
  output logic [15:0] data_o,
  output logic [1:0] is_k_o,
  output logic [1:0] frame_end_o
);
  initial begin
    sync_o = 2'b00;
    valid_o = 2'b00;
    data_o = 16'h0000;
    is_k_o = 2'b00;
    frame_end_o = 2'b00;
  end
  task automatic set_sync(input logic [1:0] s);
    sync_o <= s;
  endtask
  // idle cycles show inverted, changing data
  task automatic send(input logic [7:0] d, input logic k, input logic fe, input int gap);
    valid_o <= 2'b11;
    data_o <= {2{d}};
    is_k_o <= {2{k}};
    frame_end_o <= {2{fe}};
    @(posedge mclk_i);
    repeat (gap + 1) begin
      valid_o <= 2'b00;
      data_o <= ~data_o;
      frame_end_o <= 2'b00;
      @(posedge mclk_i);
    end
  endtask
endmodule // lane_tx_model
`default_nettype wire

// ---- rtl/deframer_lane_sync_control.v ----
/*
 * deframer_lane_sync_control.v: control and status registers of a two-lane
 * serial deframer, an axi4-lite slave, sync tracking and character replace.
 * assumes: one clock mclk_i, synchronous active-high rst_i; lane sync inputs
 * come from another domain and are synchronised here.
 */
// Decided for this implementation: the AXI4-Lite slave port.
// Behaviour
// - lane 0 sync status bit, read only, reset 0
// - receiver disable bit 7 turns receiver off
// - replace disable bit 6 stops a/f substitution
// - bit 3 holds deframer core in soft reset
// - lane 1 sync status bit at bit 1
`timescale 1ns/1ps
`default_nettype none
`include "deframer_map.vh"

module deframer_lane_sync_control #(
  parameter LANES = 2,
  parameter OCTETS_PER_FRAME = 2
) (
  input wire mclk_i,
  input wire rst_i,
  input wire [`ADDR_W-1:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [`ADDR_W-1:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire [LANES-1:0] lane_sync_i,
  input wire [LANES-1:0] lane_valid_i,
  input wire [8*LANES-1:0] lane_data_i,
  input wire [LANES-1:0] lane_is_k_i,
  input wire [LANES-1:0] lane_frame_end_i,
  output reg [LANES-1:0] lane_valid_o,
  output reg [8*LANES-1:0] lane_data_o,
  output reg [LANES-1:0] lane_is_k_o,
  output reg receiver_enable_o,
  output reg deframer_core_reset_o,
  output reg skip_initial_alignment_sequence_o,
  output reg irq_o
);

  localparam [`ADDR_W-1:0] ADDR_CTRL = {`REG_IDX_DEFRAMER_CONTROL_0, 2'b00};
  localparam [`ADDR_W-1:0] ADDR_SYNC = {`REG_IDX_SYNC_STATUS, 2'b00};
  localparam [`ADDR_W-1:0] ADDR_IRQ_STATUS = {`REG_IDX_IRQ_STATUS, 2'b00};
  localparam [`ADDR_W-1:0] ADDR_IRQ_MASK = {`REG_IDX_IRQ_MASK, 2'b00};

  reg [7:0] deframer_control_0;
  reg [3:0] irq_status;
  reg [3:0] irq_mask;
  reg [LANES-1:0] sync_meta;
  reg [LANES-1:0] sync_stable;
  reg [LANES-1:0] sync_prev;
  reg [7:0] sync_status;

  // write channel latches
  reg aw_held;
  reg w_held;
  reg [`ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire core_run;
  wire [LANES-1:0] rep_valid;
  wire [8*LANES-1:0] rep_data;
  wire [LANES-1:0] rep_is_k;
  wire wr_fire;
  wire rd_fire;
  wire irq_read;
  wire [3:0] irq_events;
  wire [`ADDR_W-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;

  // the core runs only out of soft reset and with the receiver enabled
  assign core_run = !deframer_control_0[`CTRL_SOFT_RESET_BIT] &&
    !deframer_control_0[`CTRL_RX_DISABLE_BIT];

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
      lane_char_replace #(
        .OCTETS_PER_FRAME(OCTETS_PER_FRAME)
      ) u_replace (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .enable_i(core_run),
        .replace_disable_i(deframer_control_0[`CTRL_REPLACE_DISABLE_BIT]),
        .valid_i(lane_valid_i[g]),
        .data_i(lane_data_i[8*g +: 8]),
        .is_k_i(lane_is_k_i[g]),
        .frame_end_i(lane_frame_end_i[g]),
        .valid_o(rep_valid[g]),
        .data_o(rep_data[8*g +: 8]),
        .is_k_o(rep_is_k[g])
      );
    end
  endgenerate

  // sync inputs come from the link side: two flops before use
  always @(posedge mclk_i) begin
    if (rst_i) begin
      sync_meta <= {LANES{1'b0}};
      sync_stable <= {LANES{1'b0}};
      sync_prev <= {LANES{1'b0}};
      sync_status <= `SYNC_RESET;
    end else begin
      sync_meta <= lane_sync_i;
      sync_stable <= sync_meta;
      sync_prev <= sync_stable;
      // status reads 0 while the core is held off, since no lane can be aligned then
      sync_status[`SYNC_LANE0_BIT] <= core_run & sync_stable[0];
      sync_status[`SYNC_LANE1_BIT] <= core_run & sync_stable[1];
    end
  end

  assign irq_events[`IRQ_LANE0_LOST_BIT] = sync_prev[0] & ~sync_stable[0];
  assign irq_events[`IRQ_LANE1_LOST_BIT] = sync_prev[1] & ~sync_stable[1];
  assign irq_events[`IRQ_LANE0_GAINED_BIT] = ~sync_prev[0] & sync_stable[0];
  assign irq_events[`IRQ_LANE1_GAINED_BIT] = ~sync_prev[1] & sync_stable[1];

  // write path: address and data accepted in either order
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr_i;
  assign wr_data = w_held ? w_data : s_axi_wdata_i;
  assign wr_strb = w_held ? w_strb : s_axi_wstrb_i;
  assign wr_fire = (aw_held || s_axi_awvalid_i) && (w_held || s_axi_wvalid_i) && !s_axi_bvalid_o;
  assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
  assign irq_read = rd_fire && (s_axi_araddr_i == ADDR_IRQ_STATUS);

  always @(posedge mclk_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {`ADDR_W{1'b0}};
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      deframer_control_0 <= `CTRL_RESET;
      irq_mask <= `IRQ_RESET;
    end else begin
      s_axi_awready_o <= !aw_held && !s_axi_awready_o && s_axi_awvalid_i && !s_axi_bvalid_o;
      s_axi_wready_o <= !w_held && !s_axi_wready_o && s_axi_wvalid_i && !s_axi_bvalid_o;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (aw_held && w_held && !s_axi_bvalid_o) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= `RESP_OKAY;
        if (aw_addr == ADDR_CTRL) begin
          if (w_strb[0])
            deframer_control_0 <= w_data[7:0];
        end else if (aw_addr == ADDR_IRQ_MASK) begin
          if (w_strb[0])
            irq_mask <= w_data[3:0];
        end else if (aw_addr != ADDR_SYNC && aw_addr != ADDR_IRQ_STATUS) begin
          s_axi_bresp_o <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // read path
  always @(posedge mclk_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `RESP_OKAY;
    end else begin
      s_axi_arready_o <= !s_axi_arready_o && s_axi_arvalid_i && !s_axi_rvalid_o;
      if (rd_fire) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= `RESP_OKAY;
        case (s_axi_araddr_i)
          ADDR_CTRL: s_axi_rdata_o <= {24'h000000, deframer_control_0};
          ADDR_SYNC: s_axi_rdata_o <= {24'h000000, sync_status};
          ADDR_IRQ_STATUS: s_axi_rdata_o <= {28'h0000000, irq_status};
          ADDR_IRQ_MASK: s_axi_rdata_o <= {28'h0000000, irq_mask};
          default: begin
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // sticky events; a new event in the clearing cycle survives the read
  always @(posedge mclk_i) begin
    if (rst_i) begin
      irq_status <= `IRQ_RESET;
      irq_o <= 1'b0;
    end else begin
      irq_status <= (irq_read ? 4'h0 : irq_status) | irq_events;
      irq_o <= |(((irq_read ? 4'h0 : irq_status) | irq_events) & irq_mask);
    end
  end

  // registered outputs toward the core and the lanes
  always @(posedge mclk_i) begin
    if (rst_i) begin
      receiver_enable_o <= 1'b0;
      deframer_core_reset_o <= 1'b1;
      skip_initial_alignment_sequence_o <= 1'b0;
      lane_valid_o <= {LANES{1'b0}};
      lane_data_o <= {8*LANES{1'b0}};
      lane_is_k_o <= {LANES{1'b0}};
    end else begin
      receiver_enable_o <= !deframer_control_0[`CTRL_RX_DISABLE_BIT];
      deframer_core_reset_o <= deframer_control_0[`CTRL_SOFT_RESET_BIT];
      skip_initial_alignment_sequence_o <= deframer_control_0[`CTRL_SKIP_ILAS_BIT];
      lane_valid_o <= rep_valid;
      lane_data_o <= rep_data;
      lane_is_k_o <= rep_is_k;
    end
  end

  // unused wr_* helpers kept off: writes commit from the held copies
  wire unused_ok = &{1'b0, wr_fire, wr_addr[0], wr_data[0], wr_strb[0]};

endmodule // deframer_lane_sync_control
`default_nettype wire

// ---- rtl/lane_char_replace.v ----
/*
 * lane_char_replace.v: per-lane stage that restores data octets in place of
 * /A/ and /F/ alignment characters at frame and multiframe ends.
 * assumes: mclk_i domain; lane octets arrive already 8b/10b decoded.
 */
`timescale 1ns/1ps
`default_nettype none
`include "deframer_map.vh"

module lane_char_replace #(
  parameter OCTETS_PER_FRAME = 2
) (
  input wire mclk_i,
  input wire rst_i,
  input wire enable_i,
  input wire replace_disable_i,
  input wire valid_i,
  input wire [7:0] data_i,
  input wire is_k_i,
  input wire frame_end_i,
  output reg valid_o,
  output reg [7:0] data_o,
  output reg is_k_o
);

  reg [7:0] last_octet;
  reg [7:0] next_data;
  reg next_is_k;
  wire align_char;

  assign align_char = is_k_i && frame_end_i &&
    (data_i == `CHAR_K28_3 || data_i == `CHAR_K28_7);

  always @* begin
    next_data = data_i;
    next_is_k = is_k_i;
    // alignment char at frame end stands for a repeat of the previous frame's last octet
    if (align_char && !replace_disable_i) begin
      next_data = last_octet;
      next_is_k = 1'b0;
    end
  end

  always @(posedge mclk_i) begin
    if (rst_i || !enable_i) begin
      valid_o <= 1'b0;
      data_o <= 8'h00;
      is_k_o <= 1'b0;
      last_octet <= 8'h00;
    end else begin
      valid_o <= valid_i;
      if (valid_i) begin
        data_o <= next_data;
        is_k_o <= next_is_k;
        if (frame_end_i)
          last_octet <= next_data;
      end
    end
  end

endmodule // lane_char_replace
`default_nettype wire
